// *** core/acem_monitor.v ***
`timescale 1ns/1ns
`include "acem_defines.vh"
module acem_monitor #(
    parameter MCW         = 12,
    parameter HALT_CYCLES = (`ACEM_HALT_TIME_NS * `ACEM_CLK_KHZ) / 1000000,
    parameter MISS_CYCLES = (`ACEM_MISS_TIME_NS * `ACEM_CLK_KHZ) / 1000000
) (
    // Clock and reset
    input  wire           sys_clk,
    input  wire           rst_n,
    // Register port
    input  wire [7:0]     reg_addr,
    input  wire [7:0]     reg_wdata,
    input  wire           reg_wr,
    input  wire           reg_rd,
    output reg  [7:0]     reg_rdata,
    // Audio clock pins
    input  wire           sclk,
    input  wire           lrclk,
    input  wire           mclk,
    // Other detectors and settings
    input  wire           pll_locked,
    input  wire           rate_fault,
    input  wire [4:0]     masterclk_count_tolerance,
    input  wire [7:0]     manual_sclk_divider,
    // Status outputs
    output reg            clock_error,
    output reg            converter_powerdown,
    output reg            pll_lock_status,
    output reg            bitclk_good,
    output reg            divider_autoset,
    output reg  [7:0]     sclk_divider
);

    reg  [7:0]     ctrl_ignore;
    reg  [7:0]     ctrl_counts;
    wire [3:0]     pin_sync;
    reg  [2:0]     pin_prev;
    reg  [9:0]     bit_cnt;
    reg  [9:0]     bit_prev;
    reg  [MCW-1:0] mclk_cnt;
    reg  [MCW-1:0] mclk_frame;
    reg  [7:0]     mclk_per_bit;
    reg  [7:0]     auto_div;
    reg  [3:0]     good_run;
    reg  [3:0]     bad_run;
    reg  [15:0]    halt_cnt;
    reg  [19:0]    lr_low_cnt;
    reg  [19:0]    sc_low_cnt;
    reg            ratio_ok;
    reg            first_frame;
    wire           sclk_rise;
    wire           lr_rise;
    wire           mclk_rise;
    wire           frame_valid;
    wire           ratio_fault;
    wire           halt_fault;
    wire           missing;
    wire           next_error;

    acem_sync #(
        .W (4)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({pll_locked, mclk, lrclk, sclk}),
        .sync_out (pin_sync)
    );

    // Edge detection on synchronised pins
    assign sclk_rise = pin_sync[0] & ~pin_prev[0];
    assign lr_rise   = pin_sync[1] & ~pin_prev[1];
    assign mclk_rise = pin_sync[2] & ~pin_prev[2];

    assign frame_valid = (bit_cnt >= `ACEM_BITS_MIN) &&
                         (bit_cnt <= `ACEM_BITS_MAX) &&
                         (bit_cnt == bit_prev) && !first_frame;

    function ratio_match;
        input [MCW-1:0] cnt;
        input [4:0]     tol;
        reg   [MCW:0]   ratio;
        reg   [MCW:0]   diff;
        integer         i;
        begin
            ratio_match = 1'b0;
            for (i = 0; i < 10; i = i + 1)
            begin
                case (i)
                    0: ratio = 13'h0040;
                    1: ratio = 13'h0080;
                    2: ratio = 13'h00c0;
                    3: ratio = 13'h0100;
                    4: ratio = 13'h0180;
                    5: ratio = 13'h0200;
                    6: ratio = 13'h0300;
                    7: ratio = 13'h0400;
                    8: ratio = 13'h0600;
                    default: ratio = 13'h0800;
                endcase
                diff = ({1'b0, cnt} > ratio) ? ({1'b0, cnt} - ratio)
                                             : (ratio - {1'b0, cnt});
                if (diff <= {{(MCW-4){1'b0}}, tol})
                    ratio_match = 1'b1;
            end
        end
    endfunction

    // halt after no master clock edge for the halt time
    assign halt_fault = (halt_cnt >= HALT_CYCLES);
    assign ratio_fault = !ratio_ok;
    assign missing = (lr_low_cnt >= MISS_CYCLES) ||
                     (sc_low_cnt >= MISS_CYCLES);

    assign next_error =
        (rate_fault   & ~ctrl_ignore[`ACEM_BIT_RATE]) |
        (~bitclk_good & ~ctrl_ignore[`ACEM_BIT_BITCLK]) |
        (ratio_fault  & ~ctrl_ignore[`ACEM_BIT_MCLK_RATIO]) |
        (halt_fault   & ~ctrl_ignore[`ACEM_BIT_MCLK_HALT]) |
        (~pin_sync[3] & ~ctrl_ignore[`ACEM_BIT_PLL]);

    // Register writes
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ignore <= `ACEM_RST_IGNORE;
            ctrl_counts <= `ACEM_RST_COUNTS;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `ACEM_ADDR_IGNORE)
                ctrl_ignore <= reg_wdata;
            if (reg_addr == `ACEM_ADDR_COUNTS)
                ctrl_counts <= reg_wdata;
        end
    end

    // Register reads, unmapped reads zero
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == `ACEM_ADDR_IGNORE)
                reg_rdata <= ctrl_ignore;
            else if (reg_addr == `ACEM_ADDR_COUNTS)
                reg_rdata <= ctrl_counts;
            else
                reg_rdata <= 8'h00;
        end
    end

    // Frame measurement of bit and master clocks
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_prev     <= 3'h0;
            bit_cnt      <= 10'h000;
            bit_prev     <= 10'h000;
            mclk_cnt     <= {MCW{1'b0}};
            mclk_frame   <= {MCW{1'b0}};
            mclk_per_bit <= 8'h00;
            auto_div     <= 8'h00;
            first_frame  <= 1'b1;
            ratio_ok     <= 1'b0;
        end
        else
        begin
            pin_prev <= pin_sync[2:0];
            if (lr_rise)
            begin
                bit_prev    <= bit_cnt;
                first_frame <= 1'b0;
                mclk_frame  <= mclk_cnt;
                ratio_ok    <= ratio_match(mclk_cnt,
                                           masterclk_count_tolerance);
                bit_cnt     <= {9'h000, sclk_rise};
                mclk_cnt    <= {{(MCW-1){1'b0}}, mclk_rise};
            end
            else
            begin
                if (sclk_rise && bit_cnt != 10'h3ff)
                    bit_cnt <= bit_cnt + 10'h001;
                if (mclk_rise && mclk_cnt != {MCW{1'b1}})
                    mclk_cnt <= mclk_cnt + {{(MCW-1){1'b0}}, 1'b1};
            end
            // Master clocks per bit clock for the auto divider
            // A master clock edge that lands with the bit clock edge opens
            // the next count, so it is not lost
            if (sclk_rise)
            begin
                auto_div     <= mclk_per_bit;
                mclk_per_bit <= {7'h00, mclk_rise};
            end
            else if (mclk_rise && mclk_per_bit != 8'hff)
                mclk_per_bit <= mclk_per_bit + 8'h01;
        end
    end

    // good and bad frame runs with hysteresis
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            good_run    <= 4'h0;
            bad_run     <= 4'h0;
            bitclk_good <= 1'b0;
        end
        else if (lr_rise)
        begin
            if (frame_valid)
            begin
                bad_run <= 4'h0;
                if (good_run ==
                    ctrl_counts[`ACEM_GOOD_MSB:`ACEM_GOOD_LSB])
                    bitclk_good <= 1'b1;
                else
                    good_run <= good_run + 4'h1;
            end
            else
            begin
                good_run <= 4'h0;
                if (bad_run == ctrl_counts[`ACEM_BAD_MSB:`ACEM_BAD_LSB])
                    bitclk_good <= 1'b0;
                else
                    bad_run <= bad_run + 4'h1;
            end
        end
    end

    // Halt and low-stuck timers
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            halt_cnt   <= 16'h0000;
            lr_low_cnt <= 20'h00000;
            sc_low_cnt <= 20'h00000;
        end
        else
        begin
            if (mclk_rise)
                halt_cnt <= 16'h0000;
            else if (!halt_fault)
                halt_cnt <= halt_cnt + 16'h0001;
            // high level clears the low timer
            if (pin_sync[1])
                lr_low_cnt <= 20'h00000;
            else if (lr_low_cnt < MISS_CYCLES)
                lr_low_cnt <= lr_low_cnt + 20'h00001;
            if (pin_sync[0])
                sc_low_cnt <= 20'h00000;
            else if (sc_low_cnt < MISS_CYCLES)
                sc_low_cnt <= sc_low_cnt + 20'h00001;
        end
    end

    // Registered status outputs
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_error         <= 1'b0;
            converter_powerdown <= 1'b0;
            pll_lock_status     <= 1'b0;
            divider_autoset     <= 1'b1;
            sclk_divider        <= 8'h00;
        end
        else
        begin
            clock_error <= next_error;
            converter_powerdown <= missing &
                                   ~ctrl_ignore[`ACEM_BIT_MISSING];
            pll_lock_status <= pin_sync[3];
            divider_autoset <= ~ctrl_ignore[`ACEM_BIT_AUTOSET_DIS];
            // manual value only when autoset disabled
            // manual path the host must use
            if (ctrl_ignore[`ACEM_BIT_AUTOSET_DIS])
                sclk_divider <= manual_sclk_divider;
            else
                sclk_divider <= auto_div;
        end
    end

endmodule // acem_monitor

// *** core/acem_defines.vh ***
`ifndef ACEM_DEFINES_VH
`define ACEM_DEFINES_VH

// Register addresses
`define ACEM_ADDR_IGNORE      8'h25
`define ACEM_ADDR_COUNTS      8'h26

// Reset values
`define ACEM_RST_IGNORE       8'h00
`define ACEM_RST_COUNTS       8'h11

// Ignore register field positions
`define ACEM_BIT_RESERVED     7
`define ACEM_BIT_RATE         6
`define ACEM_BIT_BITCLK       5
`define ACEM_BIT_MCLK_RATIO   4
`define ACEM_BIT_MCLK_HALT    3
`define ACEM_BIT_MISSING      2
`define ACEM_BIT_AUTOSET_DIS  1
`define ACEM_BIT_PLL          0

// Count register fields
`define ACEM_GOOD_MSB         7
`define ACEM_GOOD_LSB         4
`define ACEM_BAD_MSB          3
`define ACEM_BAD_LSB          0

// Bit clocks per frame limits
`define ACEM_BITS_MIN         10'h020
`define ACEM_BITS_MAX         10'h100

// Clock rate and timing
`define ACEM_CLK_KHZ          20000
`define ACEM_HALT_TIME_NS     2000
`define ACEM_MISS_TIME_NS     1000000

`endif

// *** core/acem_sync.v ***
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous inputs
module acem_sync #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         rst_n,
    // Data
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] stage1;

    // First stage feeds only the second
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // acem_sync

// *** tb/acem_src.sv ***
`timescale 1ns/1ns
// Serial audio source: frame, bit and master clocks
module acem_src (
    // Control from the bench
    input  wire       run,
    input  wire       park,
    input  wire [9:0] bits,
    // Audio clock pins
    output reg        sclk,
    output reg        lrclk,
    output reg        mclk
);
    integer i;
    integer n;
    // Two master clocks per bit; parked level while stopped
    initial
    begin
        {sclk, lrclk, mclk} = 3'b000;
        #7;
        forever
            if (run)
            begin
                n = bits;
                // Stop mid-frame once the bench drops run
                for (i = 0; i < n && run; i = i + 1)
                begin
                    lrclk = (i < n / 2);
                    sclk = 1'b0;
                    mclk = 1'b1;
                    #125 mclk = 1'b0;
                    #125 sclk = 1'b1;
                    mclk = 1'b1;
                    #125 mclk = 1'b0;
                    #125;
                end
            end
            else
            begin
                {sclk, lrclk, mclk} = {park, park, 1'b0};
                #125;
            end
    end
endmodule // acem_src

// *** tb/acem_monitor_asserts.sv ***
`timescale 1ns/1ns
// Port-level watch on the clock error monitor
module acem_monitor_asserts #(
    parameter MISS_CYCLES = 20000
) (
    // Clock, reset and register port
    input wire       sys_clk, rst_n, reg_wr, reg_rd,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata,
    // Pins and detector inputs
    input wire       lrclk, pll_locked,
    input wire [7:0] manual_sclk_divider, sclk_divider,
    // Status outputs
    input wire       clock_error, converter_powerdown, pll_lock_status,
    input wire       bitclk_good, divider_autoset
);
    reg  [7:0]  ign;
    reg  [7:0]  cnts;
    reg  [15:0] lo_l;
    reg  [3:0]  age;
    reg         lr_d;
    wire [7:0]  exp_rd = reg_addr == 8'h25 ? ign :
                         reg_addr == 8'h26 ? cnts : 8'h00;
    // Shadow registers, frame clock low time and frame edge age
    always @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
            ign <= 8'h00;
            cnts <= 8'h11;
            lo_l <= 16'h0000;
            age <= 4'hf;
            lr_d <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'h25) ign <= reg_wdata;
            if (reg_wr && reg_addr == 8'h26) cnts <= reg_wdata;
            lo_l <= lrclk ? 16'h0000 : lo_l + {15'h0000, lo_l != 16'hffff};
            age <= (lrclk && !lr_d) ? 4'h0 : age + {3'h0, age != 4'hf};
            lr_d <= lrclk;
        end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_read;
        reg_rd && !reg_wr;
    endsequence
    sequence s_verdict;
        $changed(bitclk_good);
    endsequence
    chk_read_back: assert property (s_read |=> reg_rdata == $past(exp_rd))
        else $error("read data differs from register");
    chk_pll_true: assert property (
        (pll_locked == $past(pll_locked))[*6] |-> pll_lock_status == pll_locked)
        else $error("lock status wrong");
    chk_pll_error: assert property (
        (!ign[0] && !pll_lock_status)[*3] |-> clock_error)
        else $error("unlock gave no clock error");
    chk_bitclk_error: assert property (
        (!ign[5] && !bitclk_good)[*3] |-> clock_error)
        else $error("bad bit clock gave no clock error");
    chk_quiet_masked: assert property (
        (ign[6:3] == 4'hf && ign[0])[*4] |-> !clock_error)
        else $error("clock error with all faults masked");
    chk_missing_low: assert property (
        (!ign[2])[*3] ##0 (lo_l > MISS_CYCLES + 8) |-> converter_powerdown)
        else $error("low clocks gave no powerdown");
    chk_div_mode: assert property (
        (ign[1] == $past(ign[1]) && $stable(manual_sclk_divider))[*3] |->
        divider_autoset == !ign[1] &&
        (!ign[1] || sclk_divider == manual_sclk_divider))
        else $error("divider mode wrong");
    chk_verdict_frame: assert property (
        s_verdict |-> age >= 4'h2 && age <= 4'ha)
        else $error("bit clock verdict off a frame edge");
endmodule // acem_monitor_asserts
bind acem_monitor acem_monitor_asserts #(.MISS_CYCLES(MISS_CYCLES)) acem_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lrclk(lrclk), .pll_locked(pll_locked),
    .manual_sclk_divider(manual_sclk_divider), .sclk_divider(sclk_divider),
    .clock_error(clock_error), .converter_powerdown(converter_powerdown),
    .pll_lock_status(pll_lock_status), .bitclk_good(bitclk_good),
    .divider_autoset(divider_autoset));

// *** tb/audio_clock_error_monitor_tb.sv ***
`timescale 1ns/1ns
module audio_clock_error_monitor_tb;
    reg         sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg         pll_locked = 1'b1, rate_fault = 1'b0, run = 1'b0, park = 1'b0;
    reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, manual = 8'h5a;
    reg  [4:0]  tol = 5'h02;
    reg  [9:0]  bits = 10'h020;
    reg  [39:0] msk = 40'h70_61_51_31_71;
    wire [7:0]  reg_rdata, sclk_divider;
    wire        sclk, lrclk, mclk, clock_error, converter_powerdown;
    wire        pll_lock_status, bitclk_good, divider_autoset;
    integer     fails = 0, samples_checked = 0, k;
    // Clock
    always #25 sys_clk = ~sys_clk;
    acem_src acem_src_inst (.run(run), .park(park), .bits(bits),
        .sclk(sclk), .lrclk(lrclk), .mclk(mclk));
    acem_monitor #(.MISS_CYCLES(2000)) acem_monitor_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sclk(sclk), .lrclk(lrclk), .mclk(mclk),
        .pll_locked(pll_locked), .rate_fault(rate_fault),
        .masterclk_count_tolerance(tol), .manual_sclk_divider(manual),
        .clock_error(clock_error), .converter_powerdown(converter_powerdown),
        .pll_lock_status(pll_lock_status), .bitclk_good(bitclk_good),
        .divider_autoset(divider_autoset), .sclk_divider(sclk_divider));
    task give_verdict;
    begin
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task check(input [7:0] seen, input [7:0] want);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== want)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: %h not %h", $time, seen, want);
        end
    end
    endtask
    task cyc(input integer n);
    begin
        repeat (n) @(posedge sys_clk);
        #2;
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    end
    endtask
    task rd(input [7:0] a, input [7:0] want);
    begin
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        cyc(1);
        check(reg_rdata, want);
    end
    endtask
    // Wait for frame clock rising edges, then let the verdict settle
    task frames(input integer n);
        integer t;
        reg     p;
    begin
        p = lrclk;
        t = 0;
        while (n > 0)
        begin
            @(posedge sys_clk);
            if (lrclk && !p) n = n - 1;
            p = lrclk;
            t = t + 1;
            if (t > 30000)
            begin
                fails = fails + 1;
                give_verdict;
            end
        end
        cyc(10);
    end
    endtask
    // Main sequence
    initial
    begin
        cyc(8);
        rst_n = 1'b1;
        cyc(1);
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h11);
        rd(8'h27, 8'h00);
        wr(8'h25, 8'h80);
        rd(8'h25, 8'h80);
        wr(8'h26, 8'h31);
        rd(8'h26, 8'h31);
        run = 1'b1;
        frames(5);
        check(bitclk_good, 8'h00);
        check(clock_error, 8'h01);
        frames(1);
        check(bitclk_good, 8'h01);
        check(divider_autoset, 8'h01);
        check(sclk_divider, 8'h02);
        check(clock_error, 8'h00);
        check(pll_lock_status, 8'h01);
        bits = 10'h021;
        frames(4);
        check(clock_error, 8'h00);
        check(bitclk_good, 8'h01);
        tol = 5'h01;
        frames(2);
        check(clock_error, 8'h01);
        bits = 10'h101;
        frames(2);
        check(bitclk_good, 8'h01);
        frames(1);
        check(bitclk_good, 8'h00);
        rate_fault = 1'b1;
        pll_locked = 1'b0;
        for (k = 0; k < 5; k = k + 1)
        begin
            wr(8'h25, msk[k * 8 +: 8]);
            cyc(6);
            check(clock_error, {7'h00, k != 0});
            check(pll_lock_status, 8'h00);
        end
        wr(8'h25, 8'h75);
        run = 1'b0;
        cyc(60);
        check(clock_error, 8'h01);
        check(converter_powerdown, 8'h00);
        wr(8'h25, 8'h7d);
        cyc(4);
        check(clock_error, 8'h00);
        wr(8'h25, 8'h79);
        cyc(2100);
        check(converter_powerdown, 8'h01);
        park = 1'b1;
        cyc(2100);
        check(converter_powerdown, 8'h00);
        // Manual dividers for an uncommon clock setup
        wr(8'h25, 8'h02);
        cyc(4);
        check(divider_autoset, 8'h00);
        check(sclk_divider, 8'h5a);
        manual = 8'h3c;
        cyc(4);
        check(sclk_divider, 8'h3c);
        give_verdict;
    end
endmodule // audio_clock_error_monitor_tb
